// ### shared/xdl_map.svh
// constants for the xor and direction-load datapath
`ifndef XDL_MAP_SVH
`define XDL_MAP_SVH
`define XDL_DATA_W     8
`define XDL_FADDR_W    7
`define XDL_OPER_W     3
`define XDL_SEL_A      3'h5
`define XDL_SEL_B      3'h6
`define XDL_SEL_C      3'h7
`define XDL_DIR_RST    8'hff
`define XDL_ACC_RST    8'h00
`define XDL_DEST_ACC   1'h0
`define XDL_DEST_FILE  1'h1
`define XDL_ZERO       8'h00
`endif

// ### shared/xdl_pkg.sv
// types for the xor and direction-load datapath
`default_nettype none
`include "xdl_map.svh"
package xdl_pkg;
   // operation codes presented by the decoder
   typedef enum logic [1:0]
   {
      xdl_op_none_type_v = 2'h0,
      xdl_op_xor_lit     = 2'h1,
      xdl_op_xor_file    = 2'h2,
      xdl_op_load_dir    = 2'h3
   } xdl_op_type;
endpackage
`default_nettype wire

// ### shared/xdl_alu_if.sv
// interface between the datapath and its xor unit
`default_nettype none
`include "xdl_map.svh"
interface xdl_alu_if;
   logic [`XDL_DATA_W-1:0] opa;     // accumulator side
   logic [`XDL_DATA_W-1:0] opb;     // literal or file side
   logic [`XDL_DATA_W-1:0] result;  // xor result
   logic                   zero;    // result is zero
   modport core (output opa, output opb, input result, input zero);
   modport unit (input opa, input opb, output result, output zero);
endinterface
`default_nettype wire

// ### logic/xdl_xor_unit.sv
// combinational xor unit with zero detect
`default_nettype none
`include "xdl_map.svh"
module xdl_xor_unit
(
   xdl_alu_if.unit alu
);
   // ----------------------------------------
   // xor and zero detect
   // ----------------------------------------
   // RULE_03 accumulator xor operand
   assign alu.result = alu.opa ^ alu.opb;
   // RULE_06 zero when all bits clear
   assign alu.zero   = (alu.result == `XDL_ACC_RST);
endmodule
`default_nettype wire

// ### logic/xdl_datapath.sv
// datapath for literal xor, file xor and direction load
// Overview of operation
// RULE_01 - literal xor result goes to accumulator
// RULE_02 - operand 5,6,7 picks direction register A,B,C
// RULE_03 - file xor combines accumulator and register
// RULE_04 - dest 0: result to accumulator only
// RULE_05 - dest 1: result to register only
// RULE_06 - xors update zero; direction load keeps flags
`default_nettype none
`include "xdl_map.svh"
module xdl_datapath
(
   input  wire logic                     sys_clk,        // core clock
   input  wire logic                     srst,           // sync reset, high
   input  wire xdl_pkg::xdl_op_type      op,             // operation this cycle
   input  wire logic [`XDL_DATA_W-1:0]   literal,        // immediate operand
   input  wire logic [`XDL_OPER_W-1:0]   dir_sel,        // direction select
   input  wire logic [`XDL_FADDR_W-1:0]  file_addr,      // file register addr
   input  wire logic                     dest,           // file xor dest bit
   input  wire logic [`XDL_DATA_W-1:0]   file_rdata,     // addressed register
   output var  logic [`XDL_DATA_W-1:0]   acc,            // working accumulator
   output var  logic                     zero_flag,      // zero status flag
   output var  logic [`XDL_DATA_W-1:0]   port_a_direction, // port A direction
   output var  logic [`XDL_DATA_W-1:0]   port_b_direction, // port B direction
   output var  logic [`XDL_DATA_W-1:0]   port_c_direction, // port C direction
   output var  logic                     file_we,        // file write strobe
   output var  logic [`XDL_FADDR_W-1:0]  file_waddr,     // file write addr
   output var  logic [`XDL_DATA_W-1:0]   file_wdata      // file write data
);
   import xdl_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   // all registered state in one record
   typedef struct packed
   {
      logic [`XDL_DATA_W-1:0]  acc;    // accumulator
      logic                    zf;     // zero flag
      logic [`XDL_DATA_W-1:0]  dira;   // port A direction
      logic [`XDL_DATA_W-1:0]  dirb;   // port B direction
      logic [`XDL_DATA_W-1:0]  dirc;   // port C direction
      logic                    we;     // write strobe
      logic [`XDL_FADDR_W-1:0] waddr;  // write address
      logic [`XDL_DATA_W-1:0]  wdata;  // write data
   } xdl_state_type;

   xdl_state_type st;       // current state
   xdl_state_type next_st;  // next state
   xdl_alu_if     alu ();   // xor unit link

   // ----------------------------------------
   // xor unit
   // ----------------------------------------
   xdl_xor_unit u_xor
   (
      .alu (alu.unit)
   );

   // literal feeds the unit only for the literal xor
   always_comb
   begin
      alu.opa = st.acc;
      alu.opb = (op == xdl_op_xor_lit) ? literal : file_rdata;
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      next_st    = st;
      next_st.we = 1'b0;  // strobe lasts one cycle
      case (op)
         xdl_op_xor_lit:
         begin
            // RULE_01 literal result to acc
            next_st.acc = alu.result;
            // RULE_06 zero from result
            next_st.zf  = alu.zero;
         end
         xdl_op_xor_file:
         begin
            // RULE_06 zero from result
            next_st.zf = alu.zero;
            if (dest == `XDL_DEST_ACC)
            begin
               // RULE_04 acc gets result
               next_st.acc = alu.result;
            end
            else
            begin
               // RULE_05 register written back
               next_st.we    = 1'b1;
               next_st.waddr = file_addr;
               next_st.wdata = alu.result;
            end
         end
         xdl_op_load_dir:
         begin
            // RULE_02 select by operand; other codes ignored
            case (dir_sel)
               `XDL_SEL_A: next_st.dira = st.acc;
               `XDL_SEL_B: next_st.dirb = st.acc;
               `XDL_SEL_C: next_st.dirc = st.acc;
               default:    next_st.dira = st.dira;
            endcase
         end
         default:
         begin
            next_st.we = 1'b0;  // idle: hold all but the strobe
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // directions reset to inputs so pins do not fight at power up
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st       <= '0;
         st.acc   <= `XDL_ACC_RST;
         st.dira  <= `XDL_DIR_RST;
         st.dirb  <= `XDL_DIR_RST;
         st.dirc  <= `XDL_DIR_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   // outputs straight from state flops
   assign acc              = st.acc;
   assign zero_flag        = st.zf;
   assign port_a_direction = st.dira;
   assign port_b_direction = st.dirb;
   assign port_c_direction = st.dirc;
   assign file_we          = st.we;
   assign file_waddr       = st.waddr;
   assign file_wdata       = st.wdata;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // reset may drop at the very edge that samples it, where the disable
   // condition already reads low; every trigger except that of we_pulse_a
   // therefore also asks for srst low, so that no $past or $stable there
   // reaches back across a reset

   // RULE_01 literal result kept
   lit_xor_acc_a: assert property (  // RULE_01
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_xor_lit |=> acc == ($past(acc) ^ $past(literal)))
      else $error("literal xor result wrong");

   // RULE_01 no file write, directions untouched
   lit_no_side_a: assert property (  // RULE_01
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_xor_lit
      |=> !file_we && $stable(port_a_direction) && $stable(port_b_direction)
          && $stable(port_c_direction))
      else $error("literal xor touched other state");

   // RULE_02 port a load
   dir_a_load_a: assert property (  // RULE_02
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_load_dir && dir_sel == `XDL_SEL_A
      |=> port_a_direction == $past(acc))
      else $error("port a direction not loaded");

   // RULE_02 port b load
   dir_b_load_a: assert property (  // RULE_02
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_load_dir && dir_sel == `XDL_SEL_B
      |=> port_b_direction == $past(acc) && $stable(port_a_direction))
      else $error("port b direction load wrong");

   // RULE_02 port c load
   dir_c_load_a: assert property (  // RULE_02
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_load_dir && dir_sel == `XDL_SEL_C
      |=> port_c_direction == $past(acc) && $stable(port_b_direction))
      else $error("port c direction load wrong");

   // RULE_02 low selects refused
   dir_refused_a: assert property (  // RULE_02
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_load_dir && dir_sel < `XDL_SEL_A
      |=> $stable(port_a_direction) && $stable(port_b_direction)
          && $stable(port_c_direction))
      else $error("refused direction select loaded");

   // RULE_03 xor of both sides
   file_xor_a: assert property (  // RULE_03
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_xor_file
      |=> (file_we ? file_wdata : acc) == ($past(acc) ^ $past(file_rdata)))
      else $error("file xor result wrong");

   // RULE_04 accumulator destination
   file_acc_dest_a: assert property (  // RULE_04
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_xor_file && dest == `XDL_DEST_ACC
      |=> acc == ($past(acc) ^ $past(file_rdata)) && !file_we)
      else $error("file xor to acc wrong");

   // RULE_05 register destination
   file_reg_dest_a: assert property (  // RULE_05
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_xor_file && dest == `XDL_DEST_FILE
      |=> file_we && $stable(acc) && file_waddr == $past(file_addr)
          && file_wdata == ($past(acc) ^ $past(file_rdata)))
      else $error("file xor write back wrong");

   // RULE_06 zero after literal
   zero_on_xor_a: assert property (  // RULE_06
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_xor_lit |=> zero_flag == (acc == `XDL_ZERO))
      else $error("zero flag wrong");

   // RULE_06 zero after file
   zero_on_file_a: assert property (  // RULE_06
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_xor_file
      |=> zero_flag == (($past(acc) ^ $past(file_rdata)) == `XDL_ZERO))
      else $error("zero flag wrong after file xor");

   // RULE_06 load keeps flags
   zero_kept_dir_a: assert property (  // RULE_06
      @(posedge sys_clk) disable iff (srst)
      !srst && op == xdl_op_load_dir |=> $stable(zero_flag) && $stable(acc))
      else $error("direction load changed flags");

   // RULE_05 strobe only on write back
   we_pulse_a: assert property (  // RULE_05
      @(posedge sys_clk) disable iff (srst)
      file_we && !($past(op) == xdl_op_xor_file && $past(dest) == `XDL_DEST_FILE) |-> 1'b0)
      else $error("stray write strobe");
endmodule
`default_nettype wire

// ### verif/xdl_datapath_tb.sv
// self-checking bench for the xor and direction-load datapath
`default_nettype none
`include "xdl_map.svh"
module xdl_datapath_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import xdl_pkg::*;
   // ------------------------------------------------
   // signals and reference state
   // ------------------------------------------------
   logic       sys_clk;        // core clock
   logic       srst;           // sync reset
   xdl_op_type op;             // operation
   logic [7:0] literal;        // immediate
   logic [2:0] dir_sel;        // direction select
   logic [6:0] file_addr;      // file address
   logic       dest;           // destination bit
   logic [7:0] file_rdata;     // memory read
   logic [7:0] acc;            // dut accumulator
   logic       zero_flag;      // dut zero flag
   logic [7:0] dir_a;          // dut direction a
   logic [7:0] dir_b;          // dut direction b
   logic [7:0] dir_c;          // dut direction c
   logic       file_we;        // dut write strobe
   logic [6:0] file_waddr;     // dut write address
   logic [7:0] file_wdata;     // dut write data
   logic [7:0] mem [0:127];    // file memory beside the dut
   logic [7:0] e_acc, e_da, e_db, e_dc, e_wd; // expected values
   logic       e_z, e_we;      // expected flags
   logic [6:0] e_wa;           // expected write address
   logic [31:0] seed;          // lfsr state
   int         failures;       // mismatch count
   int         compares;       // comparison count
   assign file_rdata = mem[file_addr];
   xdl_datapath i_dut
   (
      .sys_clk(sys_clk), .srst(srst), .op(op), .literal(literal), .dir_sel(dir_sel),
      .file_addr(file_addr), .dest(dest), .file_rdata(file_rdata), .acc(acc),
      .zero_flag(zero_flag), .port_a_direction(dir_a), .port_b_direction(dir_b),
      .port_c_direction(dir_c), .file_we(file_we), .file_waddr(file_waddr),
      .file_wdata(file_wdata)
   );
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   function automatic logic [31:0] next_rand(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // expected xor result, its zero flag in the top bit
   function automatic logic [8:0] xor_ref(input logic [7:0] a, input logic [7:0] b);
      return {(a ^ b) == 8'h00, a ^ b};
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one operation launched at a rising edge
   task automatic drive(input xdl_op_type o, input logic [7:0] l, input logic [2:0] s,
                        input logic [6:0] a, input logic d);
      @(posedge sys_clk);
      op <= o;
      literal <= l;
      dir_sel <= s;
      file_addr <= a;
      dest <= d;
   endtask
   task automatic finish_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // memory takes the dut's write pulse, as the real file would
   always @(posedge sys_clk)
      if (file_we === 1'b1)
         mem[file_waddr] <= file_wdata;
   // ------------------------------------------------
   // reference model, same edge as the dut
   // ------------------------------------------------
   always @(posedge sys_clk)
   begin
      e_we <= 1'b0;
      if (srst)
         {e_acc, e_z, e_da, e_db, e_dc} <= {`XDL_ACC_RST, 1'b0, {3{`XDL_DIR_RST}}};
      else
         case (op)
            xdl_op_xor_lit: {e_z, e_acc} <= xor_ref(e_acc, literal);
            xdl_op_xor_file:
            begin
               if (dest == `XDL_DEST_FILE)
                  {e_we, e_wa, e_z, e_wd} <= {1'b1, file_addr, xor_ref(e_acc, file_rdata)};
               else
                  {e_z, e_acc} <= xor_ref(e_acc, file_rdata);
            end
            xdl_op_load_dir:
            begin
               if (dir_sel == `XDL_SEL_A) e_da <= e_acc;
               if (dir_sel == `XDL_SEL_B) e_db <= e_acc;
               if (dir_sel == `XDL_SEL_C) e_dc <= e_acc;
            end
            default: ;
         endcase
   end
   // outputs are settled at the falling edge
   always @(negedge sys_clk)
   begin
      check("acc", acc, e_acc);
      check("zero_flag", {7'h00, zero_flag}, {7'h00, e_z});
      check("port_a_direction", dir_a, e_da);
      check("port_b_direction", dir_b, e_db);
      check("port_c_direction", dir_c, e_dc);
      check("file_we", {7'h00, file_we}, {7'h00, e_we});
      if (e_we)
      begin
         check("file_waddr", {1'b0, file_waddr}, {1'b0, e_wa});
         check("file_wdata", file_wdata, e_wd);
      end
   end
   // watchdog so a hang still reaches the verdict
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      failures++;
      finish_test();
   end
   // ------------------------------------------------
   // stimulus: corners, then random traffic
   // ------------------------------------------------
   initial
   begin
      {srst, literal, dir_sel, file_addr, dest} = {1'b1, 19'h0};
      op = xdl_op_none_type_v;
      {seed, failures, compares} = {32'hc9c4, 64'h0};
      for (int i = 0; i < 128; i++)
         mem[i] = i[7:0] * 8'h25;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      // every select, fresh accumulator each time; 0..4 must be refused
      for (int i = 0; i < 8; i++)
      begin
         drive(xdl_op_xor_lit, 8'h11 + i[7:0], 3'h0, 7'h00, 1'b0);
         drive(xdl_op_load_dir, 8'hff, i[2:0], 7'h00, 1'b0);
      end
      // zero result by literal, then by file, then back-to-back file writes
      drive(xdl_op_none_type_v, 8'h00, 3'h0, 7'h00, 1'b0);
      drive(xdl_op_none_type_v, 8'h00, 3'h0, 7'h00, 1'b0);
      drive(xdl_op_xor_lit, e_acc, 3'h0, 7'h00, 1'b0);
      drive(xdl_op_xor_file, 8'h00, 3'h0, 7'h00, `XDL_DEST_ACC);
      drive(xdl_op_xor_file, 8'h00, 3'h0, 7'h7f, `XDL_DEST_FILE);
      drive(xdl_op_xor_file, 8'h00, 3'h0, 7'h01, `XDL_DEST_FILE);
      for (int k = 0; k < 2; k++)
      begin
         repeat (400)
         begin
            seed = next_rand(seed);
            drive(xdl_op_type'(seed[1:0]), seed[9:2], seed[12:10], seed[19:13], seed[20]);
         end
         // reset in mid-run
         srst <= 1'b1;
         @(posedge sys_clk);
         srst <= 1'b0;
      end
      drive(xdl_op_none_type_v, 8'h00, 3'h0, 7'h00, 1'b0);
      repeat (2) @(posedge sys_clk);
      finish_test();
   end
endmodule
`default_nettype wire
